// ==== tb/fci_flash_model.sv ====
`timescale 1ns/1ns
module fci_flash_model
  import fci_pkg::*;
#(
  parameter logic [15:0] MAKER_ID  = 16'h00C3, // Arbitrary value
  parameter logic [15:0] DEV_ID    = 16'h5A5A, // Arbitrary value
  parameter logic        BOOT_WP_N = 1'b0,
  parameter int          PGM_NS    = 2000
)
(
  input  wire logic              ce_n_in,
  input  wire logic              we_n_in,
  input  wire logic              oe_n_in,
  input  wire logic              byte_n_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0]      dq_out,
  output logic                   rb_n_out
);
  // ------
  // Device behaviour
  // ------
  logic [15:0] mem [16];
  logic [15:0] rv, lv, pd;
  logic [ADDR_W-1:0] la;
  logic [7:0] k;
  logic busy, fl, tog, prot;
  int st;
  initial begin
    st = 0;
    busy = 0;
    fl = 0;
    tog = 0;
    lv = '0;
    for (int i = 0; i < 16; i++) mem[i] = 16'hFF00 | 16'(i);
  end
  task automatic pgm(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    // zeros stay zero, boot sector still programmable
    fl = (mem[a[3:0]] & d) != d;
    mem[a[3:0]] = mem[a[3:0]] & d;
    pd = d;
    busy = 1;
  endtask
  task automatic wcyc(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    if (busy) begin
    end
    else if (d[7:0] == CMD_RESET && st != 5) st = 0;
    else case (st)
      0: st = (a == UNLOCK1_ADDR && d[7:0] == UNLOCK1_DATA) ? 1 : 0;
      1: st = (a == UNLOCK2_ADDR && d[7:0] == UNLOCK2_DATA) ? 2 : 0;
      2: st = (a != UNLOCK1_ADDR) ? 0 : (d[7:0] == CMD_PROGRAM) ? 3 :
              (d[7:0] == CMD_AUTOSEL) ? 4 : (d[7:0] == CMD_BYPASS) ? 5 : 0;
      3: begin pgm(a, d); st = 0; end
      5: st = (d[7:0] == CMD_PROGRAM) ? 6 : (d[7:0] == CMD_BYP_EXIT) ? 7 : 5;
      6: begin pgm(a, d); st = 5; end
      7: st = (d[7:0] == CMD_BYP_EXIT2) ? 0 : 5;
      default: ;
    endcase
  endtask
  // address at later fall
  // Address moves on the same edge as the strobes, so let it settle
  always @(negedge we_n_in or negedge ce_n_in) #1 la = addr_in;
  always @(posedge we_n_in or posedge ce_n_in)
    if ((!we_n_in || !ce_n_in) && oe_n_in) wcyc(la, dq_in);
  always @(posedge busy) begin
    #(PGM_NS);
    busy = 0;
    fl = 0;
  end
  assign rb_n_out = !busy;
  always @(negedge oe_n_in) tog = !tog;
  always @* begin
    k = byte_n_in ? addr_in[7:0] : addr_in[7:0] >> 1;
    // Upper half is protected; sector 4 is the boot sector
    prot = addr_in[19] || (addr_in[19:16] == 4'h4 && !BOOT_WP_N);
    // reads during an operation return status
    if (busy) rv = {8'h00, ~pd[7], tog, fl, 5'h00};
    else if (st == 4)
      rv = (k == 0) ? MAKER_ID : (k == 1) ? DEV_ID : {15'h0, prot};
    else rv = mem[addr_in[3:0]];
  end
  // Released bus shows the inverse, never a stale match
  always @(posedge oe_n_in) lv = rv;
  assign dq_out = (!ce_n_in && !oe_n_in) ? rv : ~lv;
endmodule

// ==== tb/fci_host_monitor.sv ====
`timescale 1ns/1ns
module fci_host_monitor
  import fci_pkg::*;
(
  input wire logic              clk_in,
  input wire logic              rstn_in,
  input wire logic              ready_busy_n_in,
  input wire logic              ce_n_out,
  input wire logic              we_n_out,
  input wire logic              oe_n_out,
  input wire logic [ADDR_W-1:0] addr_out,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic              dq_oe_n_out
);
  // ------
  // Pin checks
  // ------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  wr_qual_a:
    assert property (!we_n_out |-> !ce_n_out && oe_n_out)
    else $error("write strobe not qualified");
  wr_drive_a:
    assert property (!we_n_out |-> !dq_oe_n_out)
    else $error("data not driven in write");
  no_fight_a:
    assert property (!oe_n_out |-> dq_oe_n_out)
    else $error("host drives data during read");
  wr_hold_a:
    assert property (!we_n_out && $past(!we_n_out)
      |-> $stable(addr_out) && $stable(dq_out))
    else $error("address or data moved in write");
  wr_pulse_a:
    assert property ($fell(we_n_out) |-> !we_n_out[*3] ##[1:2] we_n_out)
    else $error("write pulse length wrong");
  ce_after_a:
    assert property ($rose(we_n_out) |-> !ce_n_out ##1 ce_n_out)
    else $error("chip enable not released after write");
  rd_pulse_a:
    assert property ($fell(oe_n_out) |-> !oe_n_out[*5] ##[1:2] oe_n_out)
    else $error("read pulse length wrong");
  rd_addr_a:
    assert property (!oe_n_out && $past(!oe_n_out) |-> $stable(addr_out))
    else $error("address moved in read");
  cover property ($rose(we_n_out));
  cover property ($fell(oe_n_out));
  cover property ($fell(ready_busy_n_in));
endmodule

bind fci_host fci_host_monitor u_mon (
  .clk_in(clk_in), .rstn_in(rstn_in), .ready_busy_n_in(ready_busy_n_in),
  .ce_n_out(ce_n_out), .we_n_out(we_n_out), .oe_n_out(oe_n_out),
  .addr_out(addr_out), .dq_out(dq_out), .dq_oe_n_out(dq_oe_n_out));

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
module testbench;
  import fci_pkg::*;
  // ------
  // Harness
  // ------
  localparam logic [15:0] MAKER_ID = 16'h00C3; // Arbitrary value
  localparam logic [15:0] DEV_ID   = 16'h5A5A; // Arbitrary value
  logic clk_in, rstn_in, wr, rdn, rb_n, ce_n, we_n, oe_n, byte_n, dq_oe_n;
  logic [3:0] ra;
  logic [31:0] wd, rdata, s;
  logic [DATA_W-1:0] dq_h, dq_m, dq_bus;
  logic [ADDR_W-1:0] fa;
  int fail_count, compares;
  assign dq_bus = !dq_oe_n ? dq_h : dq_m;
  fci_host u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .reg_addr_in(ra),
    .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rdn),
    .reg_rdata_out(rdata), .dq_in(dq_bus), .ready_busy_n_in(rb_n),
    .ce_n_out(ce_n), .we_n_out(we_n), .oe_n_out(oe_n), .byte_n_out(byte_n),
    .addr_out(fa), .dq_out(dq_h), .dq_oe_n_out(dq_oe_n));
  fci_flash_model #(.MAKER_ID(MAKER_ID), .DEV_ID(DEV_ID)) u_flash (
    .ce_n_in(ce_n), .we_n_in(we_n), .oe_n_in(oe_n), .byte_n_in(byte_n),
    .addr_in(fa), .dq_in(dq_bus), .dq_out(dq_m), .rb_n_out(rb_n));
  initial begin
    clk_in = 0;
    forever #10 clk_in = ~clk_in;
  end
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e, input string m);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_in);
    ra <= a;
    rdn <= 1'b1;
    @(posedge clk_in);
    rdn <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic op(input logic [OP_W-1:0] o, input logic [ADDR_W-1:0] a,
                    input logic [15:0] d, input logic b);
    int n;
    wreg(REG_ADDR, {12'h000, a});
    wreg(REG_WDATA, {16'h0000, d});
    wreg(REG_CTRL, {23'h000000, b, 1'b1, 4'h0, o});
    repeat (2) @(posedge clk_in);
    n = 0;
    s = 32'h1;
    while (s[0] !== 1'b0) begin
      rreg(REG_STATUS, s);
      n++;
      if (n > 2000) begin
        fail_count++;
        $display("[ERR] %0t op hang", $time);
        tally_and_finish;
      end
    end
  endtask
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [15:0] e,
                      input logic b, input string m);
    op(OP_READ, a, 16'h0000, b);
    rreg(REG_RDATA, s);
    chk(s, {16'h0000, e}, m);
  endtask
  task automatic stat(input int bit_i, input logic e, input string m);
    rreg(REG_STATUS, s);
    chk({31'h0, s[bit_i]}, {31'h0, e}, m);
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_power;
    rchk(20'h00003, 16'hFF03, 1'b0, "power-up read");
    rreg(4'hF, s);
    chk(s, 32'h0, "unmapped");
    $display("t_power done");
  endtask
  task automatic t_program;
    op(OP_PROGRAM, 20'h00005, 16'h3C05, 1'b0);
    stat(2, 1'b1, "done flag");
    stat(3, 1'b0, "no fail");
    rchk(20'h00005, 16'h3C05, 1'b0, "programmed");
    rchk(20'h00006, 16'hFF06, 1'b0, "neighbour");
    op(OP_PROGRAM, 20'h40009, 16'h5509, 1'b0);
    rchk(20'h40009, 16'h5509, 1'b0, "boot sector program");
    $display("t_program done");
  endtask
  task automatic t_fail;
    op(OP_PROGRAM, 20'h00005, 16'hFFFF, 1'b0);
    stat(3, 1'b1, "fail flag");
    rchk(20'h00005, 16'h3C05, 1'b0, "zeros kept");
    wreg(REG_CTRL, 32'h00000200);
    op(OP_RESET, 20'hABCDE, 16'h0000, 1'b0);
    stat(3, 1'b0, "fail cleared");
    rchk(20'h00006, 16'hFF06, 1'b0, "array after");
    $display("t_fail done");
  endtask
  task automatic t_autosel;
    op(OP_AUTOSEL, 20'h00000, 16'h0000, 1'b0);
    stat(5, 1'b1, "autoselect flag");
    rchk(20'h00000, MAKER_ID, 1'b0, "maker");
    rchk(20'h00001, DEV_ID, 1'b0, "device word");
    rchk(20'h00001, DEV_ID, 1'b0, "repeat read");
    rchk(20'h80002, 16'h0001, 1'b0, "protected");
    rchk(20'h00002, 16'h0000, 1'b0, "unprotected");
    rchk(20'h40002, 16'h0001, 1'b0, "boot protect");
    rchk(20'h00002, DEV_ID, 1'b1, "device byte");
    rchk(20'h80004, 16'h0001, 1'b1, "protected byte");
    op(OP_RESET, 20'h5A5A5, 16'h0000, 1'b0);
    rchk(20'h00003, 16'hFF03, 1'b0, "array after exit");
    $display("t_autosel done");
  endtask
  task automatic t_bypass;
    op(OP_BYPASS, 20'h00000, 16'h0000, 1'b0);
    stat(6, 1'b1, "bypass flag");
    op(OP_BYP_PGM, 20'h00007, 16'h0F0F, 1'b0);
    op(OP_BYP_PGM, 20'h00008, 16'h00FF, 1'b0);
    op(OP_BYP_EXIT, 20'h00000, 16'h0000, 1'b0);
    stat(6, 1'b0, "bypass left");
    rchk(20'h00007, 16'h0F07, 1'b0, "bypass data 1");
    rchk(20'h00008, 16'h0008, 1'b0, "bypass data 2");
    $display("t_bypass done");
  endtask
  initial begin
    rstn_in = 0;
    wr = 0;
    rdn = 0;
    ra = '0;
    wd = '0;
    fail_count = 0;
    compares = 0;
    repeat (20) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    t_power;
    t_program;
    t_fail;
    t_autosel;
    t_bypass;
    tally_and_finish;
  end
endmodule

// ==== verilog/fci_bus_cycle.sv ====
`timescale 1ns/1ns
module fci_bus_cycle
  import fci_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rstn_in,
  fci_cyc_if.cyc                 cyc,
  input  wire logic [DATA_W-1:0] dq_sync_in,
  output logic                   ce_n_out,
  output logic                   we_n_out,
  output logic                   oe_n_out,
  output logic [ADDR_W-1:0]      addr_out,
  output logic [DATA_W-1:0]      dq_out,
  output logic                   dq_oe_n_out
);

  typedef enum logic [1:0] {C_IDLE, C_PULSE, C_HOLD} fci_cst_t;
  typedef struct packed {
    fci_cst_t          st;
    logic [CNT_W-1:0]  cnt;
    logic              wr;
    logic              ce_n;
    logic              we_n;
    logic              oe_n;
    logic              dq_oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
    logic [DATA_W-1:0] rd;
    logic              done;
  } fci_cyc_t;

  fci_cyc_t s_q;
  fci_cyc_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      C_IDLE: begin
        if (cyc.start) begin
          s_d.addr = cyc.addr;
          s_d.dq   = cyc.wdata;
          s_d.wr   = cyc.is_write;
          s_d.ce_n = 1'b0;
          // [R01] write qualified
          s_d.we_n    = !cyc.is_write;
          s_d.oe_n    = cyc.is_write;
          s_d.dq_oe_n = !cyc.is_write;
          s_d.cnt = cyc.is_write ? PULSE_CNT : ACCESS_CNT;
          s_d.st  = C_PULSE;
        end
      end
      C_PULSE: begin
        if (s_q.cnt > CNT_W'(1)) begin
          s_d.cnt = s_q.cnt - CNT_W'(1);
        end else begin
          // [R04] we rises first
          s_d.we_n = 1'b1;
          if (!s_q.wr) begin
            s_d.rd = dq_sync_in;
          end
          s_d.st = C_HOLD;
        end
      end
      C_HOLD: begin
        // Chip enable and output enable lift after write enable, so
        // address and data hold past the latching edge.
        s_d.ce_n    = 1'b1;
        s_d.oe_n    = 1'b1;
        s_d.dq_oe_n = 1'b1;
        s_d.done    = 1'b1;
        s_d.st      = C_IDLE;
      end
      default: s_d.st = C_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_q <= '{st: C_IDLE, cnt: '0, wr: 1'b0, ce_n: 1'b1, we_n: 1'b1,
               oe_n: 1'b1, dq_oe_n: 1'b1, addr: '0, dq: '0,
               rd: RDATA_RST, done: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign ce_n_out    = s_q.ce_n;
  assign we_n_out    = s_q.we_n;
  assign oe_n_out    = s_q.oe_n;
  assign addr_out    = s_q.addr;
  assign dq_out      = s_q.dq;
  assign dq_oe_n_out = s_q.dq_oe_n;
  assign cyc.done    = s_q.done;
  assign cyc.rdata   = s_q.rd;

endmodule

// ==== verilog/fci_cyc_if.sv ====
`timescale 1ns/1ns
interface fci_cyc_if;
  import fci_pkg::*;
  logic              start;
  logic              is_write;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              done;
  logic [DATA_W-1:0] rdata;
  modport seq (output start, is_write, addr, wdata, input done, rdata);
  modport cyc (input start, is_write, addr, wdata, output done, rdata);
endinterface

// ==== verilog/fci_host.sv ====
`timescale 1ns/1ns
module fci_host
  import fci_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rstn_in,
  input  wire logic [3:0]        reg_addr_in,
  input  wire logic [31:0]       reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic [31:0]            reg_rdata_out,
  input  wire logic [DATA_W-1:0] dq_in,
  input  wire logic              ready_busy_n_in,
  output logic                   ce_n_out,
  output logic                   we_n_out,
  output logic                   oe_n_out,
  output logic                   byte_n_out,
  output logic [ADDR_W-1:0]      addr_out,
  output logic [DATA_W-1:0]      dq_out,
  output logic                   dq_oe_n_out
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    H_IDLE, H_ISSUE, H_WAIT, H_NEXT, H_BUSY, H_POLL, H_DONE
  } fci_hst_t;

  typedef struct packed {
    fci_hst_t          st;
    logic [OP_W-1:0]   op;
    logic [2:0]        step;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic              byte_n;
    logic              bypass;
    logic              autosel;
    logic              fail;
    logic              done_flag;
    logic              start;
    logic              is_write;
    logic [ADDR_W-1:0] c_addr;
    logic [DATA_W-1:0] c_data;
    logic [1:0]        rb_sync;
    logic [DATA_W-1:0] dq_s1;
    logic [DATA_W-1:0] dq_s2;
    logic [31:0]       rd_out;
  } fci_st_t;

  fci_st_t s_q;
  fci_st_t s_d;

  fci_cyc_if cif ();

  fci_bus_cycle u_cyc (
    .clk_in      (clk_in),
    .rstn_in     (rstn_in),
    .cyc         (cif.cyc),
    .dq_sync_in  (s_q.dq_s2),
    .ce_n_out    (ce_n_out),
    .we_n_out    (we_n_out),
    .oe_n_out    (oe_n_out),
    .addr_out    (addr_out),
    .dq_out      (dq_out),
    .dq_oe_n_out (dq_oe_n_out)
  );

  assign cif.start    = s_q.start;
  assign cif.is_write = s_q.is_write;
  assign cif.addr     = s_q.c_addr;
  assign cif.wdata    = s_q.c_data;

  // Number of bus cycles in each sequence
  function automatic logic [2:0] seq_len(input logic [OP_W-1:0] op);
    case (op)
      OP_PROGRAM:  seq_len = 3'd4;
      OP_AUTOSEL:  seq_len = 3'd3;
      OP_BYPASS:   seq_len = 3'd3;
      OP_BYP_PGM:  seq_len = 3'd2;
      OP_BYP_EXIT: seq_len = 3'd2;
      default:     seq_len = 3'd1;
    endcase
  endfunction

  function automatic logic [ADDR_W+DATA_W:0] cyc_word(
    input logic [OP_W-1:0] op, input logic [2:0] step,
    input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [ADDR_W-1:0] ca;
    logic [7:0]        cd;
    ca = UNLOCK1_ADDR;
    cd = CMD_RESET;
    cyc_word = '0;
    // [R23] unlock pairs
    if ((op == OP_PROGRAM || op == OP_AUTOSEL || op == OP_BYPASS) &&
        step < 3'd2) begin
      ca = (step == 3'd0) ? UNLOCK1_ADDR : UNLOCK2_ADDR;
      cd = (step == 3'd0) ? UNLOCK1_DATA : UNLOCK2_DATA;
      cyc_word = {1'b1, ca, 8'h00, cd};
    end else begin
      case (op)
        OP_READ: cyc_word = {1'b0, a, 16'h0000};
        // [R07] single reset cycle
        OP_RESET: cyc_word = {1'b1, a, 8'h00, CMD_RESET};
        // [R12] autoselect command
        OP_AUTOSEL: cyc_word = {1'b1, UNLOCK1_ADDR, 8'h00, CMD_AUTOSEL};
        // [R21] bypass entry
        OP_BYPASS: cyc_word = {1'b1, UNLOCK1_ADDR, 8'h00, CMD_BYPASS};
        // [R17] program four cycles
        OP_PROGRAM: cyc_word = (step == 3'd2) ?
          {1'b1, UNLOCK1_ADDR, 8'h00, CMD_PROGRAM} : {1'b1, a, d};
        OP_BYP_PGM: cyc_word = (step == 3'd0) ?
          {1'b1, a, 8'h00, CMD_PROGRAM} : {1'b1, a, d};
        // [R22] bypass exit pair
        OP_BYP_EXIT: cyc_word = (step == 3'd0) ?
          {1'b1, a, 8'h00, CMD_BYP_EXIT} : {1'b1, a, 8'h00, CMD_BYP_EXIT2};
        default: cyc_word = {1'b0, a, 16'h0000};
      endcase
    end
  endfunction

  logic [ADDR_W+DATA_W:0] w;
  logic                   prog_op;
  logic [31:0]            status;

  always_comb begin
    s_d        = s_q;
    s_d.start  = 1'b0;
    s_d.rb_sync = {s_q.rb_sync[0], ready_busy_n_in};
    s_d.dq_s1  = dq_in;
    s_d.dq_s2  = s_q.dq_s1;
    w       = cyc_word(s_q.op, s_q.step, s_q.addr, s_q.wdata);
    prog_op = (s_q.op == OP_PROGRAM) || (s_q.op == OP_BYP_PGM);
    status  = {24'h0, 1'b0, s_q.bypass, s_q.autosel, !s_q.byte_n,
               s_q.fail, s_q.done_flag, s_q.rb_sync[1],
               (s_q.st != H_IDLE)};
    // ---------------------------------------------------------------
    // Register port
    // ---------------------------------------------------------------
    s_d.rd_out = 32'h0;
    if (reg_rd_in) begin
      case (reg_addr_in)
        REG_ADDR:   s_d.rd_out = 32'(s_q.addr);
        REG_WDATA:  s_d.rd_out = 32'(s_q.wdata);
        REG_STATUS: s_d.rd_out = status;
        REG_RDATA:  s_d.rd_out = 32'(s_q.rdata);
        default:    s_d.rd_out = 32'h0;
      endcase
    end
    if (reg_wr_in) begin
      case (reg_addr_in)
        REG_ADDR:  s_d.addr  = reg_wdata_in[ADDR_W-1:0];
        REG_WDATA: s_d.wdata = reg_wdata_in[DATA_W-1:0];
        REG_CTRL: begin
          s_d.byte_n = !reg_wdata_in[8];
          // Writing CTRL with the clear bit drops sticky flags; a new
          // operation start clears only done_flag and leaves fail set.
          if (reg_wdata_in[9]) begin
            s_d.done_flag = 1'b0;
            s_d.fail      = 1'b0;
          end
          // [R19] no commands while busy
          if (reg_wdata_in[7] && s_q.st == H_IDLE) begin
            s_d.op        = reg_wdata_in[OP_W-1:0];
            s_d.step      = 3'd0;
            s_d.done_flag = 1'b0;
            s_d.st        = H_ISSUE;
          end
        end
        default: ;
      endcase
    end
    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    case (s_q.st)
      H_IDLE: ;
      H_ISSUE: begin
        s_d.start    = 1'b1;
        s_d.is_write = w[ADDR_W+DATA_W];
        s_d.c_addr   = w[ADDR_W+DATA_W-1:DATA_W];
        s_d.c_data   = w[DATA_W-1:0];
        s_d.st       = H_WAIT;
      end
      H_WAIT: begin
        if (cif.done) begin
          if (!s_q.is_write) begin
            // [R13] [R14] [R15] autoselect data read
            s_d.rdata = cif.rdata;
          end
          s_d.st = H_NEXT;
        end
      end
      H_NEXT: begin
        if (s_q.step + 3'd1 < seq_len(s_q.op)) begin
          s_d.step = s_q.step + 3'd1;
          s_d.st   = H_ISSUE;
        end else if (prog_op) begin
          s_d.st = H_BUSY;
        end else begin
          s_d.st = H_DONE;
        end
      end
      H_BUSY: begin
        // Poll by reading the program address: a released bus
        // carries no status, so it must be read out
        s_d.start    = 1'b1;
        s_d.is_write = 1'b0;
        s_d.c_addr   = s_q.addr;
        s_d.st       = H_POLL;
      end
      H_POLL: begin
        if (cif.done) begin
          // [R11] limit exceeded seen
          // Busy sync lags the sampled data, so busy here means the
          // word read was status and not array contents
          if (cif.rdata[5] && !s_q.rb_sync[1]) begin
            s_d.fail = 1'b1;
          end
          // [R18] wait on ready/busy
          if (s_q.rb_sync[1]) begin
            s_d.st = H_DONE;
          end else begin
            s_d.st = H_BUSY;
          end
        end
      end
      H_DONE: begin
        case (s_q.op)
          // [R10] reset leaves autoselect
          OP_RESET: begin
            s_d.autosel = 1'b0;
            s_d.bypass  = 1'b0;
          end
          OP_AUTOSEL:  s_d.autosel = 1'b1;
          OP_BYPASS:   s_d.bypass  = 1'b1;
          OP_BYP_EXIT: s_d.bypass  = 1'b0;
          default: ;
        endcase
        s_d.done_flag = 1'b1;
        s_d.st        = H_IDLE;
      end
      default: s_d.st = H_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_q <= '0;
      s_q.st <= H_IDLE;
      // Word mode out of reset
      s_q.byte_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_out = s_q.rd_out;
  assign byte_n_out    = s_q.byte_n;

endmodule

// ==== verilog/fci_pkg.sv ====
// Contract
// [R01] Write cycle needs chip and write enable low, output enable high.
// [R02] Device ignores writes during power-up and comes up in array read.
// [R03] Wrong value or order of cycle returns device to array read.
// [R04] Device latches address at the later fall, data at the earlier rise.
// [R05] Array reads need no command after power-up or embedded operations.
// [R06] In erase suspend, suspended sectors read status, others read array.
// [R07] One reset command cycle, any address, returns device to array read.
// [R08] Reset aborts an erase sequence before erasing; ignored while erasing.
// [R09] Reset aborts a program sequence before it runs; ignored while running.
// [R10] Reset aborts autoselect entry; host writes reset to leave autoselect.
// [R11] On limit exceeded during program or erase, host writes reset command; fci_host only sets the fail flag and issues no reset.
// [R12] Two unlocks plus autoselect command enter autoselect; reads repeat.
// [R13] Autoselect 00h gives maker code; 01h word or 02h byte device code.
// [R14] Autoselect 02h word or 04h byte at sector: 01h protected, else 00h.
// [R15] Boot sector reports protected if protected or boot-protect input low.
// [R16] Boot-protect alone blocks erasure but still allows programming.
// [R17] Program is two unlocks, set-up command, then address and data.
// [R18] Program end frees the address; status bits and ready/busy show it.
// [R19] Commands ignored while programming; hardware reset ends it at once.
// [R20] Program never turns 0 into 1; order and sector crossings are free.
// [R21] Two unlocks plus 20h enter bypass; programs are A0h then address/data.
// [R22] Bypass accepts only program and reset; leave with 90h then 00h.
// [R23] Unlock and set-up address/data pairs come from the command table.
package fci_pkg;

  // ---------------------------------------------------------------
  // Bus widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;

  // ---------------------------------------------------------------
  // Command words
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 20'h00555;
  localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 20'h002AA;
  localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
  localparam logic [7:0] UNLOCK2_DATA = 8'h55;
  localparam logic [7:0] CMD_PROGRAM  = 8'hA0;
  localparam logic [7:0] CMD_AUTOSEL  = 8'h90;
  localparam logic [7:0] CMD_BYPASS   = 8'h20;
  localparam logic [7:0] CMD_BYP_EXIT = 8'h90;
  localparam logic [7:0] CMD_BYP_EXIT2 = 8'h00;
  localparam logic [7:0] CMD_RESET    = 8'hF0;

  // ---------------------------------------------------------------
  // Autoselect low addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] AS_MAKER_LO  = 8'h00;
  localparam logic [7:0] AS_DEV_LO_W  = 8'h01;
  localparam logic [7:0] AS_DEV_LO_B  = 8'h02;
  localparam logic [7:0] AS_PROT_LO_W = 8'h02;
  localparam logic [7:0] AS_PROT_LO_B = 8'h04;
  localparam logic [7:0] AS_PROT_YES  = 8'h01;

  // ---------------------------------------------------------------
  // Host command port map
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_ADDR   = 4'h1;
  localparam logic [3:0] REG_WDATA  = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RDATA  = 4'h4;
  localparam int OP_W = 3;
  localparam logic [OP_W-1:0] OP_READ    = 3'h0;
  localparam logic [OP_W-1:0] OP_PROGRAM = 3'h1;
  localparam logic [OP_W-1:0] OP_RESET   = 3'h2;
  localparam logic [OP_W-1:0] OP_AUTOSEL = 3'h3;
  localparam logic [OP_W-1:0] OP_BYPASS  = 3'h4;
  localparam logic [OP_W-1:0] OP_BYP_PGM = 3'h5;
  localparam logic [OP_W-1:0] OP_BYP_EXIT = 3'h6;

  // ---------------------------------------------------------------
  // Timing at 50 MHz
  // ---------------------------------------------------------------
  localparam int CLK_NS       = 20;
  localparam int PULSE_NS     = 60;
  localparam int PULSE_CYC    = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACCESS_NS    = 90;
  localparam int ACCESS_CYC   = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W        = 4;
  localparam logic [CNT_W-1:0] PULSE_CNT  = CNT_W'(PULSE_CYC);
  localparam logic [CNT_W-1:0] ACCESS_CNT = CNT_W'(ACCESS_CYC);

  localparam logic [DATA_W-1:0] RDATA_RST = 16'h0000;

endpackage
